// File: bench/fan_speed_alarm_control_tb.sv
// Self-checking bench for the fan controller core.
// Assumes the host model drives the link port on its own clock.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fan_speed_alarm_control_tb;
  import fsc_pkg::*;
  logic       clk, link_clk, reset, override_n, remote_open;
  logic       link_wr, alarm_n, led_green, led_red;
  logic [7:0] link_addr, link_wdata, link_rdata, fan_drive;
  logic [7:0] remote_temp, board_temp, rd_v, t;
  logic [3:0] tach_pin;
  int         n_errors, num_checks, cyc, tcnt, sl;
  int         per[4];

  // Design under test with short window and ramp step.
  fsc_top #(.WIN_CYC(200), .RAMP_STEP(2)) dut (
    .clk(clk), .reset(reset), .link_clk(link_clk), .link_wr(link_wr),
    .link_addr(link_addr), .link_wdata(link_wdata),
    .link_rdata(link_rdata), .tach_pin(tach_pin),
    .override_n(override_n), .remote_temp(remote_temp),
    .board_temp(board_temp), .remote_open(remote_open),
    .fan_drive(fan_drive), .alarm_n(alarm_n), .led_green(led_green),
    .led_red(led_red));

  // Host model on the link side.
  fsc_host host (
    .link_clk(link_clk), .link_rdata(link_rdata), .link_wr(link_wr),
    .link_addr(link_addr), .link_wdata(link_wdata));

  // Core clock of 20 ns and link clock of 125 ns.
  always #10 clk = ~clk;
  always #62.5 link_clk = ~link_clk;

  // Tach pulses, one square wave per fan with its own period.
  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    for (int i = 0; i < 4; i++) begin
      tach_pin[i] <= ((tcnt % per[i]) < per[i] / 2);
    end
  end

  // A hang is cut short and counted as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end

  // Expected drive of the temperature curve.
  function automatic logic [7:0] curve(input int tt, input int ctl,
                                       input int s, input int off);
    if (tt < off) return 8'h00;
    if (tt >= ctl) return 8'hFF;
    if (tt <= ctl - s) return 8'h80;
    return 8'(128 + (127 * (tt - (ctl - s))) / s);
  endfunction

  // Compare one value and report a mismatch at once. The ports are wide
  // enough that the alarm pin packed beside the drive byte is compared.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Let a write cross into the core and the snapshot refresh.
  task automatic settle();
    repeat (60) @(posedge clk);
  endtask

  // Register write followed by settling time.
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    settle();
  endtask

  // Register read compared with an expected byte.
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rd_v);
    chk(rd_v, e);
  endtask

  // Counts and verdict, then the end of the run.
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'hDAEC8301));
    clk = 1'b0;
    link_clk = 1'b0;
    reset = 1'b1;
    override_n = 1'b1;
    remote_open = 1'b0;
    remote_temp = 8'h14;
    board_temp = 8'h1E;
    tcnt = 0;
    cyc = 0;
    per = '{4, 4, 4, 4};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    chk(fan_drive, 8'h00);
    chk({5'h00, alarm_n, led_green, led_red}, 8'h06);
    repeat (100) @(posedge clk);
    chk({7'h00, fan_drive != 8'h00 && fan_drive != 8'hFF}, 8'h01);
    repeat (500) @(posedge clk);
    chk(fan_drive, 8'h80);
    rdc(`FSC_A_CTL, 8'h28);
    rdc(`FSC_A_CFG, 8'hF0);
    rdc(8'h10, 8'h00);
    rdc(`FSC_A_STS, 8'h00);
    rdc(`FSC_A_RTMP, remote_temp);
    rdc(`FSC_A_BTMP, board_temp);
    // Temperature curve: corners first, then random points.
    for (int k = 0; k < 12; k++) begin
      if (k == 6) wrs(`FSC_A_CFG, 8'hF4);
      sl = (k < 6) ? 5 : 10;
      t = (k == 0) ? 8'h23 : (k == 1) ? 8'h28 : 8'($urandom_range(48, 26));
      remote_temp <= t;
      settle();
      chk(fan_drive, curve(int'(t), 40, sl, 0));
    end
    // Board sensor selected while the remote one stays cool.
    remote_temp <= 8'h14;
    board_temp <= 8'h2D;
    wrs(`FSC_A_CFG, 8'hF2);
    chk(fan_drive, 8'hFF);
    wrs(`FSC_A_CFG, 8'hF0);
    wrs(`FSC_A_OFF, 8'h19);
    chk(fan_drive, 8'h00);
    wrs(`FSC_A_OFF, 8'h00);
    // Over temperature: ignored until enabled, then full drive.
    wrs(`FSC_A_CTL, 8'h3C);
    remote_temp <= 8'h32;
    wrs(`FSC_A_ALM, 8'h2A);
    chk({alarm_n, fan_drive}, 9'h180);
    wrs(`FSC_A_CFG, 8'hF8);
    chk(fan_drive, 8'hFF);
    chk({5'h00, alarm_n, led_green, led_red}, 8'h01);
    rdc(`FSC_A_STS, 8'h20);
    rdc(`FSC_A_CTL, 8'h3C);
    wrs(`FSC_A_CFG, 8'hF0);
    wrs(`FSC_A_CTL, 8'h28);
    remote_temp <= 8'h14;
    // Open remote sensor.
    remote_open <= 1'b1;
    settle();
    chk({alarm_n, fan_drive}, 9'h0FF);
    rdc(`FSC_A_STS, 8'h10);
    remote_open <= 1'b0;
    // Slow fan two fails, then it is disabled.
    per[2] = 40;
    repeat (450) @(posedge clk);
    chk({alarm_n, fan_drive}, 9'h0FF);
    rdc(`FSC_A_STS, 8'h04);
    wrs(`FSC_A_CFG, 8'hB0);
    rdc(`FSC_A_STS, 8'h00);
    chk({alarm_n, fan_drive}, 9'h180);
    // A lower threshold lets the slow fan pass.
    wrs(`FSC_A_CFG, 8'hF0);
    wrs(`FSC_A_THR, 8'h04);
    repeat (450) @(posedge clk);
    chk({alarm_n, fan_drive}, 9'h180);
    wrs(`FSC_A_THR, 8'h14);
    per[2] = 4;
    repeat (450) @(posedge clk);
    // Override pin forces full drive without an alarm.
    override_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk({alarm_n, fan_drive}, 9'h1FF);
    override_n <= 1'b1;
    settle();
    chk(fan_drive, 8'h80);
    // Speed command switches to bus control.
    wrs(`FSC_A_CMD, 8'h55);
    chk(fan_drive, 8'h55);
    rdc(`FSC_A_CFG, 8'hF1);
    remote_temp <= 8'h2D;
    settle();
    chk(fan_drive, 8'h55);
    wrs(`FSC_A_CFG, 8'hF0);
    chk(fan_drive, 8'hFF);
    // A write to a read-only address must leave the setup untouched.
    wrs(`FSC_A_STS, 8'h01);
    rdc(`FSC_A_CFG, 8'hF0);
    chk({alarm_n, fan_drive}, 9'h1FF);
    print_verdict();
  end
endmodule
`default_nettype wire

// File: bench/fsc_host.sv
// Host model on the link port: single byte writes and reads.
// Assumes the core takes link_wr on the rising link clock edge.
`timescale 1ns/1ps
`default_nettype none
module fsc_host (
  input  wire logic       link_clk,
  input  wire logic [7:0] link_rdata,
  output logic            link_wr,
  output logic      [7:0] link_addr,
  output logic      [7:0] link_wdata
);
  // The port is idle at time zero.
  initial begin
    link_wr = 1'b0;
    link_addr = 8'h00;
    link_wdata = 8'h00;
  end

  // One write pulse, then an idle cycle so writes keep their spacing.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge link_clk);
    link_wr <= 1'b1;
    link_addr <= a;
    link_wdata <= d;
    @(posedge link_clk);
    link_wr <= 1'b0;
    link_wdata <= ~d;
    @(posedge link_clk);
  endtask

  // Present an address and take the byte registered one cycle later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge link_clk);
    link_addr <= a;
    @(posedge link_clk);
    @(posedge link_clk);
    d = link_rdata;
  endtask
endmodule
`default_nettype wire

// File: design/fsc_link.sv
// Link side register port, clocked by the link clock.
// Assumes link signals come from logic on the link clock.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_link
  import fsc_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       reset,
  input  wire logic       link_wr,
  input  wire logic [7:0] link_addr,
  input  wire logic [7:0] link_wdata,
  input  wire fsc_stat_t  sts,
  input  wire logic       sts_tgl,
  output logic      [7:0] link_rdata,
  output fsc_wr_t         wr_hold,
  output logic            wr_tgl,
  output logic            sts_ack
);
  // All state of the link port.
  typedef struct packed {
    logic [1:0] rst_s;
    logic [2:0] req_s;
    fsc_stat_t  snap;
    fsc_wr_t    wr;
    logic       tgl;
    logic [7:0] rdata;
  } fsc_link_st_t;

  fsc_link_st_t r;
  fsc_link_st_t n;

  // Captures snapshots, launches writes and answers reads.
  always_comb begin
    n       = r;
    n.rst_s = {r.rst_s[0], reset};
    n.req_s = {r.req_s[1:0], sts_tgl};
    if (r.req_s[1] != r.req_s[2]) begin
      n.snap = sts;
    end
    if (link_wr) begin
      n.wr  = '{addr: link_addr, data: link_wdata};
      n.tgl = ~r.tgl;
    end
    case (link_addr)
      `FSC_A_STS:  n.rdata = r.snap.flags;
      `FSC_A_CFG:  n.rdata = r.snap.cfg;
      `FSC_A_CTL:  n.rdata = r.snap.ctl;
      `FSC_A_RTMP: n.rdata = r.snap.rtemp;
      `FSC_A_BTMP: n.rdata = r.snap.btemp;
      default:     n.rdata = 8'h00;
    endcase
  end

  // The core reset reaches this domain through two flops.
  always_ff @(posedge link_clk) begin
    if (r.rst_s[1]) begin
      r       <= '0;
      r.rst_s <= n.rst_s;
    end else begin
      r <= n;
    end
  end

  assign link_rdata = r.rdata;
  assign wr_hold    = r.wr;
  assign wr_tgl     = r.tgl;
  assign sts_ack    = r.req_s[2];
endmodule
`default_nettype wire

// File: design/fsc_tach.sv
// Tach pulse counters for four fans with a common measurement window.
// Assumes tach pins are asynchronous; each passes two flops first.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_tach
  import fsc_pkg::*;
#(
  parameter int WIN_CYC = `FSC_WIN_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] tach_pin,
  input  wire logic [7:0] thr,
  output logic      [3:0] fail
);
  // All state of the counters.
  typedef struct packed {
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [3:0]      s3;
    logic [3:0][7:0] cnt;
    logic [3:0]      fail;
    logic [31:0]     win;
  } fsc_tach_st_t;

  fsc_tach_st_t r;
  fsc_tach_st_t n;
  logic         win_end;

  assign win_end = (r.win == 32'(WIN_CYC - 1));

  // Count rising edges per fan; each count unit is 100 pulses per minute.
  always_comb begin
    n    = r;
    n.s1 = tach_pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.win = win_end ? 32'h0 : r.win + 32'h1;
    for (int i = 0; i < 4; i++) begin
      if (win_end) begin
        n.fail[i] = (r.cnt[i] < thr);
        n.cnt[i]  = 8'h00;
      end else if (r.s2[i] && !r.s3[i] && r.cnt[i] != 8'hFF) begin
        n.cnt[i] = r.cnt[i] + 8'h01;
      end
    end
  end

  // Registers the counter state; no fan is failed out of reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign fail = r.fail;
endmodule
`default_nettype wire

// File: design/fsc_top.sv
// Fan speed and alarm controller core for up to four fans.
// Assumes temperatures come from a converter on clk and the link port
// is driven by logic on link_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_top
  import fsc_pkg::*;
#(
  parameter int WIN_CYC   = `FSC_WIN_CYC,
  parameter int RAMP_STEP = `FSC_RAMP_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       link_clk,
  input  wire logic       link_wr,
  input  wire logic [7:0] link_addr,
  input  wire logic [7:0] link_wdata,
  output logic      [7:0] link_rdata,
  input  wire logic [3:0] tach_pin,
  input  wire logic       override_n,
  input  wire logic [7:0] remote_temp,
  input  wire logic [7:0] board_temp,
  input  wire logic       remote_open,
  output logic      [7:0] fan_drive,
  output logic            alarm_n,
  output logic            led_green,
  output logic            led_red
);
  // All state of the core.
  typedef struct packed {
    fsc_state_t  st;      // Soft start or running.
    logic [31:0] tmr;     // Ramp step timer.
    logic [7:0]  drive;   // Fan voltage code, FF is full supply.
    fsc_cfg_t    cfg;     // Mode, sensor, slope, alarm enable, fans.
    logic [7:0]  cmd;     // Bus speed command.
    logic [7:0]  off_t;   // Off temperature.
    logic [7:0]  alm_t;   // Alarm temperature.
    logic [7:0]  thr;     // Tach threshold in hundreds per minute.
    logic [7:0]  ctl_t;   // Control temperature.
    logic [2:0]  wr_s;    // Write toggle synchroniser and last value.
    logic [1:0]  ack_s;   // Snapshot acknowledge synchroniser.
    logic [1:0]  ovr_s;   // Override pin synchroniser.
    logic        alarm_n; // Alarm pin, low in alarm.
    logic        led_g;   // Normal indicator.
    logic        led_r;   // Alarm indicator.
    logic        sts_tgl; // Snapshot request toggle.
    fsc_stat_t   snap;    // Snapshot offered to the link.
  } fsc_core_t;

  // Reset state carries every documented default.
  localparam fsc_core_t CORE_RST = '{
    st:      FSC_RAMP,
    tmr:     32'h0,
    drive:   8'h00,
    cfg:     `FSC_CFG_RST,
    cmd:     `FSC_CMD_RST,
    off_t:   `FSC_OFF_RST,
    alm_t:   `FSC_ALM_RST,
    thr:     `FSC_THR_RST,
    ctl_t:   `FSC_CTL_RST,
    wr_s:    3'h0,
    ack_s:   2'h0,
    ovr_s:   2'h3,
    alarm_n: 1'b1,
    led_g:   1'b1,
    led_r:   1'b0,
    sts_tgl: 1'b0,
    snap:    '0
  };

  fsc_core_t   r;         // Registered state.
  fsc_core_t   n;         // Next state.
  fsc_wr_t     wr_hold;   // Write held stable by the link port.
  logic        wr_tgl;    // Flips once per link write.
  logic        sts_ack;   // Echo of the snapshot toggle.
  logic [3:0]  fail;      // Per fan tach failure.
  logic [3:0]  fail_m;    // Failures of enabled fans only.
  logic        wr_evt;    // One write arrived this cycle.
  logic [7:0]  sel_t;     // Temperature of the chosen sensor.
  logic [7:0]  slope;     // Degrees between idle and full.
  logic [7:0]  lo_t;      // Top of the idle band.
  logic [7:0]  delta;     // Degrees above the idle band.
  logic [15:0] prod;      // Drive span times delta.
  logic [15:0] quo;       // Proportional part of the drive.
  logic [7:0]  temp_v;    // Drive asked for by temperature.
  logic [7:0]  target;    // Drive asked for by the active mode.
  logic        fan_alm;   // Some enabled fan is slow.
  logic        open_alm;  // Remote sensor is open.
  logic        ot_alm;    // Over temperature.
  logic        any_alm;   // Any alarm condition.
  logic        full_req;  // Alarm or override wants full drive.
  logic        step_end;  // Ramp step timer expired.

  // Link side port on its own clock.
  fsc_link u_link (
    .link_clk   (link_clk),
    .reset      (reset),
    .link_wr    (link_wr),
    .link_addr  (link_addr),
    .link_wdata (link_wdata),
    .sts        (r.snap),
    .sts_tgl    (r.sts_tgl),
    .link_rdata (link_rdata),
    .wr_hold    (wr_hold),
    .wr_tgl     (wr_tgl),
    .sts_ack    (sts_ack)
  );

  // Tach counters for the four fan headers.
  fsc_tach #(
    .WIN_CYC (WIN_CYC)
  ) u_tach (
    .clk      (clk),
    .reset    (reset),
    .tach_pin (tach_pin),
    .thr      (r.thr),
    .fail     (fail)
  );

  // A write is taken when the synchronised toggle changes.
  assign wr_evt = r.wr_s[1] ^ r.wr_s[2];

  // Temperature to drive mapping.
  assign sel_t  = r.cfg.board_sel ? board_temp : remote_temp;
  assign slope  = r.cfg.slope10 ? `FSC_SLOPE_HI : `FSC_SLOPE_LO;
  assign lo_t   = (r.ctl_t > slope) ? r.ctl_t - slope : 8'h00;
  assign delta  = sel_t - lo_t;
  assign prod   = 16'(`FSC_FULL - `FSC_IDLE) * 16'(delta);
  assign quo    = prod / 16'(slope);
  assign temp_v = (sel_t < r.off_t) ? 8'h00 :
                  (sel_t >= r.ctl_t) ? `FSC_FULL :
                  (sel_t <= lo_t) ? `FSC_IDLE :
                  `FSC_IDLE + quo[7:0];
  assign target = r.cfg.bus_mode ? r.cmd : temp_v;

  // Alarm sources; disabled fans never count.
  assign fail_m   = fail & r.cfg.fan_en;
  assign fan_alm  = |fail_m;
  assign open_alm = ~r.cfg.bus_mode & ~r.cfg.board_sel & remote_open;
  assign ot_alm   = ~r.cfg.bus_mode & r.cfg.ot_en & (sel_t > r.alm_t);
  assign any_alm  = fan_alm | open_alm | ot_alm;
  assign full_req = any_alm | ~r.ovr_s[1];
  assign step_end = (r.tmr == 32'(RAMP_STEP - 1));

  // Next state: writes, sequencing, alarms and the status snapshot.
  always_comb begin
    n       = r;
    n.wr_s  = {r.wr_s[1:0], wr_tgl};
    n.ack_s = {r.ack_s[0], sts_ack};
    n.ovr_s = {r.ovr_s[0], override_n};
    // Register writes from the host.
    if (wr_evt) begin
      case (wr_hold.addr)
        `FSC_A_CFG: n.cfg = wr_hold.data;
        `FSC_A_CMD: begin
          n.cmd          = wr_hold.data;
          n.cfg.bus_mode = 1'b1;
        end
        `FSC_A_OFF: n.off_t = wr_hold.data;
        `FSC_A_ALM: n.alm_t = wr_hold.data;
        `FSC_A_THR: n.thr   = wr_hold.data;
        `FSC_A_CTL: n.ctl_t = wr_hold.data;
        default:    n.cfg   = r.cfg;
      endcase
    end
    // Drive sequencing.
    case (r.st)
      FSC_RAMP: begin
        if (step_end) begin
          n.tmr = 32'h0;
          if (r.drive == `FSC_FULL) begin
            n.st = FSC_RUN;
          end else begin
            n.drive = r.drive + 8'h01;
          end
        end else begin
          n.tmr = r.tmr + 32'h1;
        end
      end
      FSC_RUN: begin
        n.drive = full_req ? `FSC_FULL : target;
      end
      default: begin
        n.st = FSC_RAMP;
      end
    endcase
    // Alarm pin and indicators.
    n.alarm_n = ~any_alm;
    n.led_g   = ~any_alm;
    n.led_r   = any_alm;
    // Offer a fresh snapshot once the last one was taken.
    if (r.ack_s[1] == r.sts_tgl) begin
      n.snap.flags = {2'b00, ot_alm, open_alm, fail_m};
      n.snap.cfg   = r.cfg;
      n.snap.ctl   = r.ctl_t;
      n.snap.rtemp = remote_temp;
      n.snap.btemp = board_temp;
      n.sts_tgl    = ~r.sts_tgl;
    end
  end

  // Registers the core; reset restores the defaults.
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  assign fan_drive = r.drive;
  assign alarm_n   = r.alarm_n;
  assign led_green = r.led_g;
  assign led_red   = r.led_r;

  // Checks on the core, all in the clk domain.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // A speed command write arriving.
  sequence s_cmd_write;
    wr_evt && wr_hold.addr == `FSC_A_CMD;
  endsequence

  // A ramp step finishing below full.
  sequence s_ramp_step;
    r.st == FSC_RAMP && step_end && r.drive != `FSC_FULL;
  endsequence

  a_ramp_step: assert property (
    s_ramp_step |=> fan_drive == $past(fan_drive) + 8'h01)
    else $error("ramp step did not raise drive by one");

  a_ramp_done: assert property (
    r.st == FSC_RAMP && step_end && fan_drive == `FSC_FULL
    |=> r.st == FSC_RUN)
    else $error("ramp did not hand over at full drive");

  a_cmd_mode: assert property (
    s_cmd_write |=> r.cfg.bus_mode && r.cmd == $past(wr_hold.data))
    else $error("speed command did not select bus mode");

  a_alarm_full: assert property (
    r.st == FSC_RUN && any_alm |=> fan_drive == `FSC_FULL)
    else $error("alarm did not force full drive");

  a_alarm_pin: assert property (
    any_alm |=> !alarm_n && led_red && !led_green)
    else $error("alarm outputs did not follow alarm");

  a_override_full: assert property (
    r.st == FSC_RUN && !r.ovr_s[1] |=> fan_drive == `FSC_FULL)
    else $error("override did not force full drive");

  a_off_zero: assert property (
    r.st == FSC_RUN && !r.cfg.bus_mode && sel_t < r.off_t
    && !full_req |=> fan_drive == 8'h00)
    else $error("drive not zero below off temperature");

  a_ctl_full: assert property (
    r.st == FSC_RUN && !r.cfg.bus_mode && sel_t >= r.ctl_t
    && sel_t >= r.off_t |=> fan_drive == `FSC_FULL)
    else $error("drive not full at control temperature");

  a_ot_alarm: assert property (
    !r.cfg.bus_mode && r.cfg.ot_en && sel_t > r.alm_t
    |=> !alarm_n)
    else $error("over temperature did not raise alarm");

  a_fan_mask: assert property (
    !open_alm && !ot_alm && (fail & r.cfg.fan_en) == 4'h0
    |=> alarm_n)
    else $error("disabled fan raised an alarm");
endmodule
`default_nettype wire

// File: pkg/fsc_consts.svh
// Constants of the fan speed and alarm controller: offsets, reset values
// and timing counts. Included by every design file that needs them.
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
`define FSC_A_CFG    8'hF0
`define FSC_A_CMD    8'hF1
`define FSC_A_OFF    8'hF2
`define FSC_A_ALM    8'hF3
`define FSC_A_THR    8'hF4
`define FSC_A_CTL    8'hF8
`define FSC_A_STS    8'hE0
`define FSC_A_RTMP   8'hE1
`define FSC_A_BTMP   8'hE2
`define FSC_CFG_RST  8'hF0
`define FSC_CTL_RST  8'h28
`define FSC_OFF_RST  8'h00
`define FSC_ALM_RST  8'hFF
`define FSC_THR_RST  8'h14
`define FSC_CMD_RST  8'hFF
`define FSC_SLOPE_LO 8'h05
`define FSC_SLOPE_HI 8'h0A
`define FSC_FULL     8'hFF
`define FSC_IDLE     8'h80
`define FSC_CLK_MHZ  50
`define FSC_WIN_MS   600
`define FSC_WIN_CYC  (`FSC_WIN_MS * 1000 * `FSC_CLK_MHZ)
`define FSC_RAMP_US  40
`define FSC_RAMP_CYC (`FSC_RAMP_US * `FSC_CLK_MHZ)
`endif

// File: pkg/fsc_pkg.sv
// Types shared by the controller core, the link port and the tach block.
// Assumes the constants header is compiled alongside.
package fsc_pkg;
  // Core sequencing: soft start ramp, then normal running.
  typedef enum logic [0:0] {FSC_RAMP, FSC_RUN} fsc_state_t;
  // Configuration byte, most significant field first.
  typedef struct packed {
    logic [3:0] fan_en;
    logic       ot_en;
    logic       slope10;
    logic       board_sel;
    logic       bus_mode;
  } fsc_cfg_t;
  // One register write carried from the link to the core.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } fsc_wr_t;
  // Status snapshot carried from the core to the link.
  typedef struct packed {
    logic [7:0] flags;
    fsc_cfg_t   cfg;
    logic [7:0] ctl;
    logic [7:0] rtemp;
    logic [7:0] btemp;
  } fsc_stat_t;
endpackage
